// ==== rtl/mts_map.svh ====
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH
// Contract
// - Device address word is 1010000 plus direction; A0h writes, A1h reads.
// - Bus traffic is matched and answered only while module select is low.
// - Current-address read acks A1h, sends byte at pointer; host NACKs, STOPs.
// - Random read: A0h, byte address, repeated START, then current-address read.
// - Host ACK after a read byte fetches next byte; NACK then STOP ends.
// - Byte write acks address word, memory address, data; commits after STOP.
// - Repeated START instead of STOP aborts the write, discarding its data.
// - After write STOP a timed write cycle runs; bus ignored until done.
// - Sequential write takes up to four data bytes, each acknowledged.
// - Sequential write not ended by STOP is aborted and its data discarded.
// - Lower space of 128 bytes always addressable; upper pages selected apart.
// - A lower-space byte chooses the upper page for later accesses.
// - Lower page and upper page 00 exist; pages 02, 03 exist; 01 absent.
// - Within 2000 ms of reset release: interrupt asserted, not-ready cleared.
// - Reset pin low longer than 2 us counts as a reset request.
// - Bus answers no later than 2000 ms after power on.
// - Within 2000 ms clear not-ready bit 0 of byte 2, assert interrupt.
// - Low-power pin asserted drops device to low power within 100 us.
// - Flagged condition latches flag and drives interrupt low in time.
// - Reading a latched flag clears it; interrupt releases within 500 us.
// - Mask bit set suppresses its interrupt; cleared restores it, 100 ms.
// - Rate select change reaches the bandwidth control within 100 us.
// - Software power-down enters low power; clearing restores full function.
// - Timed write cycle of up to four bytes completes within 40 ms.
// - Byte 93 bit 0 override, bit 1 power set; else pin decides.
// - Deselect at any point releases SCL and SDA within 2 ms.
`define MTS_DEV_ADDR    7'h50
`define MTS_CLK_MHZ     100
`define MTS_T_INIT_MS   2000
`define MTS_T_WR_MS     40
`define MTS_T_RST_US    2
`define MTS_INIT_CYC    (`MTS_T_INIT_MS * 1000 * `MTS_CLK_MHZ)
`define MTS_WR_CYC      (`MTS_T_WR_MS * 1000 * `MTS_CLK_MHZ)
`define MTS_RST_CYC     (`MTS_T_RST_US * `MTS_CLK_MHZ)
`define MTS_WR_MAX      3'h4
`define MTS_MEM_DEPTH   512
`define MTS_ADR_ID      7'h00
`define MTS_ADR_STATUS  7'h02
`define MTS_ADR_LOS     7'h03
`define MTS_ADR_TXF     7'h04
`define MTS_ADR_CTRL    7'h56
`define MTS_ADR_RATE    7'h57
`define MTS_ADR_POWER   7'h5D
`define MTS_ADR_MSK_LOS 7'h64
`define MTS_ADR_MSK_TXF 7'h65
`define MTS_ADR_PAGE    7'h7F
`define MTS_BIT_NRDY    0
`define MTS_BIT_INT     1
`define MTS_BIT_FLAT    2
`define MTS_BIT_OVR     0
`define MTS_BIT_PSET    1
`define MTS_PAGE_00     8'h00
`define MTS_PAGE_02     8'h02
`define MTS_PAGE_03     8'h03
`endif

// ==== rtl/mts_pkg.sv ====
package mts_pkg;

    typedef enum logic [3:0]
    {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h3,
        ST_WADR      = 4'h2,
        ST_WADR_ACK  = 4'h6,
        ST_WDATA     = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RLOAD     = 4'h4,
        ST_RDATA     = 4'hC,
        ST_RACK      = 4'hD,
        ST_BUSY      = 4'hF
    } mts_state_t;

    typedef struct packed
    {
        logic       scl;
        logic       sda;
        logic       sel_n;
        logic       rst_n;
        logic       lp;
        logic [3:0] los;
        logic [3:0] txf;
    } mts_pins_t;

    typedef struct packed
    {
        mts_state_t      state;
        logic [3:0]      cnt;
        logic [7:0]      sh;
        logic            rw;
        logic            ack;
        logic            sda_drv;
        logic [7:0]      ptr;
        logic [2:0]      nbytes;
        logic [3:0][7:0] wbuf;
        logic [2:0]      ci;
        logic [7:0]      wptr;
        logic [27:0]     timer;
        logic [7:0]      rst_cnt;
        logic            init_busy;
        logic            not_ready;
        logic            init_flag;
        logic [3:0]      los_flag;
        logic [3:0]      txf_flag;
        logic [3:0]      los_mask;
        logic [3:0]      txf_mask;
        logic [7:0]      page;
        logic [7:0]      rate;
        logic            pwr_ovr;
        logic            pwr_set;
        logic            int_n;
        logic            lp_out;
        logic            scl_q;
        logic            sda_q;
    } mts_regs_t;

endpackage

// ==== rtl/mts_sync.sv ====
`timescale 1ns/1ps
module mts_sync
    import mts_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_reg <= '0;
            q_out    <= '0;
        end
        else
        begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule

// ==== rtl/mts_mem.sv ====
`timescale 1ns/1ps
`include "mts_map.svh"
module mts_mem
    import mts_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       we_in,
    input  wire logic [8:0] waddr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic [8:0] raddr_in,
    output logic      [7:0] rdata_out
);
    logic [7:0] mem_array [0:`MTS_MEM_DEPTH-1];

    always_ff @(posedge clk_in)
    begin
        if (we_in)
            mem_array[waddr_in] <= wdata_in;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_out <= 8'h00;
        else
            rdata_out <= mem_array[raddr_in];
    end
endmodule

// ==== rtl/mts_slave.sv ====
`timescale 1ns/1ps
`include "mts_map.svh"
module mts_slave
    import mts_pkg::*;
#(
    parameter logic [27:0] INIT_CYC  = 28'(`MTS_INIT_CYC),
    parameter logic [27:0] WR_CYC    = 28'(`MTS_WR_CYC),
    parameter logic [7:0]  ID_BYTE   = 8'h5A
)
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       module_select_n_in,
    input  wire logic       module_reset_n_in,
    input  wire logic       low_power_pin_in,
    input  wire logic [3:0] rx_los_in,
    input  wire logic [3:0] tx_fault_in,
    output logic            sda_out,
    output logic            sda_oe_n_out,
    output logic            interrupt_n_out,
    output logic            low_power_out,
    output logic      [7:0] rate_select_out,
    output logic            ready_out
);
    // ID_BYTE value is arbitrary

    localparam logic [7:0] RST_CYC = 8'(`MTS_RST_CYC);

    mts_regs_t  r;
    mts_regs_t  n;
    mts_pins_t  pin_raw;
    mts_pins_t  pin;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic       rst_req;
    logic       mem_we;
    logic [8:0] mem_wa;
    logic [7:0] mem_wd;
    logic [8:0] mem_ra;
    logic [7:0] mem_rd;
    logic [2:0] rd_bank;
    logic [2:0] wr_bank;
    logic [7:0] rd_byte;
    logic       clr_los;
    logic       clr_txf;
    logic       clr_init;
    logic       int_pend;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and memory

    assign pin_raw = {scl_in, sda_in, module_select_n_in,
                      module_reset_n_in, low_power_pin_in,
                      rx_los_in, tx_fault_in};

    mts_sync #(
        .W        ($bits(mts_pins_t))
    ) u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .d_in     (pin_raw),
        .q_out    (pin)
    );

    mts_mem u_mem (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .we_in     (mem_we),
        .waddr_in  (mem_wa),
        .wdata_in  (mem_wd),
        .raddr_in  (mem_ra),
        .rdata_out (mem_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Page decode

    // Returns {valid, bank}: lower, page 00, page 02, page 03
    function automatic logic [2:0] bank_of(input logic [7:0] a,
                                           input logic [7:0] pg);
        logic [2:0] b;
        b = 3'h0;
        if (!a[7])
            b = 3'h4;
        else if (pg == `MTS_PAGE_00)
            b = 3'h5;
        else if (pg == `MTS_PAGE_02)
            b = 3'h6;
        else if (pg == `MTS_PAGE_03)
            b = 3'h7;
        return b;
    endfunction

    function automatic logic can_write(input logic [7:0] a,
                                       input logic [7:0] pg);
        logic w;
        if (!a[7])
            w = (a[6:0] >= `MTS_ADR_CTRL);
        else
            w = (pg == `MTS_PAGE_02) || (pg == `MTS_PAGE_03);
        return w;
    endfunction

    assign rd_bank = bank_of(r.ptr, r.page);
    assign wr_bank = bank_of(r.wptr, r.page);
    assign mem_ra  = {rd_bank[1:0], r.ptr[6:0]};

    ////////////////////////////////////////////////////////////////////////
    // Read data overlay

    always_comb
    begin
        rd_byte = mem_rd;
        if (!rd_bank[2])
            rd_byte = 8'h00;
        else if (!r.ptr[7])
        begin
            unique case (r.ptr[6:0])
                `MTS_ADR_ID:
                    rd_byte = ID_BYTE;
                `MTS_ADR_STATUS:
                begin
                    rd_byte = 8'h00;
                    rd_byte[`MTS_BIT_NRDY] = r.not_ready;
                    rd_byte[`MTS_BIT_INT]  = r.int_n;
                    rd_byte[`MTS_BIT_FLAT] = 1'b1;
                end
                `MTS_ADR_LOS:
                    rd_byte = {4'h0, r.los_flag};
                `MTS_ADR_TXF:
                    rd_byte = {4'h0, r.txf_flag};
                `MTS_ADR_PAGE:
                    rd_byte = r.page;
                default:
                    rd_byte = mem_rd;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus conditions

    assign rise  = pin.scl & ~r.scl_q;
    assign fall  = ~pin.scl & r.scl_q;
    assign start = pin.scl & r.scl_q & r.sda_q & ~pin.sda;
    assign stop  = pin.scl & r.scl_q & ~r.sda_q & pin.sda;
    assign rst_req = pin.rst_n && (r.rst_cnt > RST_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        n        = r;
        mem_we   = 1'b0;
        mem_wa   = {wr_bank[1:0], r.wptr[6:0]};
        mem_wd   = r.wbuf[r.ci[1:0]];
        clr_los  = 1'b0;
        clr_txf  = 1'b0;
        clr_init = 1'b0;
        n.scl_q  = pin.scl;
        n.sda_q  = pin.sda;

        if (!pin.rst_n)
        begin
            if (r.rst_cnt != 8'hFF)
                n.rst_cnt = r.rst_cnt + 8'h01;
        end
        else
            n.rst_cnt = 8'h00;

        if (r.init_busy)
        begin
            if (r.timer == 28'h0)
            begin
                n.init_busy = 1'b0;
                n.not_ready = 1'b0;
                n.init_flag = 1'b1;
            end
            else
                n.timer = r.timer - 28'h1;
        end

        if (r.state == ST_BUSY)
        begin
            if (r.ci != r.nbytes)
            begin
                mem_we = wr_bank[2] && can_write(r.wptr, r.page);
                if (!r.wptr[7])
                begin
                    unique case (r.wptr[6:0])
                        `MTS_ADR_RATE:
                            n.rate = mem_wd;
                        `MTS_ADR_POWER:
                        begin
                            n.pwr_ovr = mem_wd[`MTS_BIT_OVR];
                            n.pwr_set = mem_wd[`MTS_BIT_PSET];
                        end
                        `MTS_ADR_MSK_LOS:
                            n.los_mask = mem_wd[3:0];
                        `MTS_ADR_MSK_TXF:
                            n.txf_mask = mem_wd[3:0];
                        `MTS_ADR_PAGE:
                            n.page = mem_wd;
                        default:
                            n.rate = r.rate;
                    endcase
                end
                n.ci   = r.ci + 3'h1;
                n.wptr = r.wptr + 8'h01;
            end
            if (r.timer == 28'h0)
            begin
                n.state  = ST_IDLE;
                n.nbytes = 3'h0;
            end
            else
                n.timer = r.timer - 28'h1;
        end
        else if (pin.sel_n || r.init_busy)
        begin
            n.state   = ST_IDLE;
            n.sda_drv = 1'b0;
            n.nbytes  = 3'h0;
        end
        else if (start)
        begin
            n.state   = ST_ADDR;
            n.cnt     = 4'h0;
            n.nbytes  = 3'h0;
            n.sda_drv = 1'b0;
        end
        else if (stop)
        begin
            n.sda_drv = 1'b0;
            n.state   = ST_IDLE;
            if ((r.state == ST_WDATA || r.state == ST_WDATA_ACK)
                && r.nbytes != 3'h0)
            begin
                n.state = ST_BUSY;
                n.ci    = 3'h0;
                n.wptr  = r.ptr;
                n.ptr   = r.ptr + {5'h00, r.nbytes};
                n.timer = WR_CYC - 28'h1;
            end
            else
                n.nbytes = 3'h0;
        end
        else
        begin
            if (rise && r.state != ST_RDATA && r.state != ST_RACK)
            begin
                n.sh  = {r.sh[6:0], pin.sda};
                n.cnt = r.cnt + 4'h1;
            end
            unique case (r.state)
                ST_IDLE:
                    n.sda_drv = 1'b0;
                ST_ADDR:
                    if (fall && r.cnt == 4'h8)
                    begin
                        if (r.sh[7:1] == `MTS_DEV_ADDR)
                        begin
                            n.rw      = r.sh[0];
                            n.sda_drv = 1'b1;
                            n.state   = ST_ADDR_ACK;
                        end
                        else
                            n.state = ST_IDLE;
                    end
                ST_ADDR_ACK:
                    if (fall)
                    begin
                        n.sda_drv = 1'b0;
                        n.cnt     = 4'h0;
                        n.state   = r.rw ? ST_RLOAD : ST_WADR;
                    end
                ST_WADR:
                    if (fall && r.cnt == 4'h8)
                    begin
                        n.ptr     = r.sh;
                        n.sda_drv = 1'b1;
                        n.state   = ST_WADR_ACK;
                    end
                ST_WADR_ACK:
                    if (fall)
                    begin
                        n.sda_drv = 1'b0;
                        n.cnt     = 4'h0;
                        n.state   = ST_WDATA;
                    end
                ST_WDATA:
                    if (fall && r.cnt == 4'h8)
                    begin
                        if (r.nbytes < `MTS_WR_MAX)
                        begin
                            n.wbuf[r.nbytes[1:0]] = r.sh;
                            n.nbytes  = r.nbytes + 3'h1;
                            n.sda_drv = 1'b1;
                            n.state   = ST_WDATA_ACK;
                        end
                        else
                        begin
                            n.nbytes = 3'h0;
                            n.state  = ST_IDLE;
                        end
                    end
                ST_WDATA_ACK:
                    if (fall)
                    begin
                        n.sda_drv = 1'b0;
                        n.cnt     = 4'h0;
                        n.state   = ST_WDATA;
                    end
                ST_RLOAD:
                begin
                    n.sh      = rd_byte;
                    n.sda_drv = ~rd_byte[7];
                    n.cnt     = 4'h0;
                    n.ptr     = r.ptr + 8'h01;
                    n.state   = ST_RDATA;
                    if (rd_bank[2] && !r.ptr[7])
                    begin
                        clr_los  = r.ptr[6:0] == `MTS_ADR_LOS;
                        clr_txf  = r.ptr[6:0] == `MTS_ADR_TXF;
                        clr_init = r.ptr[6:0] == `MTS_ADR_STATUS;
                    end
                end
                ST_RDATA:
                begin
                    if (rise)
                        n.cnt = r.cnt + 4'h1;
                    if (fall)
                    begin
                        if (r.cnt == 4'h8)
                        begin
                            n.sda_drv = 1'b0;
                            n.state   = ST_RACK;
                        end
                        else
                        begin
                            n.sh      = {r.sh[6:0], 1'b0};
                            n.sda_drv = ~r.sh[6];
                        end
                    end
                end
                ST_RACK:
                begin
                    if (rise)
                        n.ack = ~pin.sda;
                    if (fall)
                        n.state = r.ack ? ST_RLOAD : ST_IDLE;
                end
                default:
                    n.state = ST_IDLE;
            endcase
        end

        // Flags latch; a new condition wins over a clear
        n.los_flag  = (clr_los ? 4'h0 : r.los_flag) | pin.los;
        n.txf_flag  = (clr_txf ? 4'h0 : r.txf_flag) | pin.txf;
        n.init_flag = clr_init ? 1'b0 : n.init_flag;
        int_pend    = n.init_flag
                      | (|(n.los_flag & ~n.los_mask))
                      | (|(n.txf_flag & ~n.txf_mask));
        n.int_n     = ~int_pend;
        n.lp_out    = n.pwr_ovr ? n.pwr_set : pin.lp;

        if (rst_req)
        begin
            n           = '0;
            n.state     = ST_IDLE;
            n.init_busy = 1'b1;
            n.not_ready = 1'b1;
            n.timer     = INIT_CYC - 28'h1;
            n.int_n     = 1'b1;
            n.lp_out    = pin.lp;
            n.scl_q     = pin.scl;
            n.sda_q     = pin.sda;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            r           <= '0;
            r.state     <= ST_IDLE;
            r.init_busy <= 1'b1;
            r.not_ready <= 1'b1;
            r.timer     <= INIT_CYC - 28'h1;
            r.int_n     <= 1'b1;
        end
        else
            r <= n;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign sda_out         = 1'b0;
    assign sda_oe_n_out    = ~r.sda_drv;
    assign interrupt_n_out = r.int_n;
    assign low_power_out   = r.lp_out;
    assign rate_select_out = r.rate;
    assign ready_out       = ~r.not_ready;
endmodule

// ==== verif/mts_chk.sv ====
`timescale 1ns/1ps
module mts_chk
    import mts_pkg::*;
#(
    parameter logic [27:0] INIT = 28'h00000C8
)
(
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       module_select_n_in,
    input wire logic       module_reset_n_in,
    input wire logic       low_power_pin_in,
    input wire logic       sda_oe_n_out,
    input wire logic       interrupt_n_out,
    input wire logic       low_power_out,
    input wire logic [7:0] rate_select_out,
    input wire logic       ready_out
);
    logic [27:0] up_reg;
    logic [3:0]  lo_reg;
    logic [3:0]  st_reg;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////
    // Ages since reset pin release and since bus stop
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            up_reg <= 28'h0000000;
            lo_reg <= 4'hF;
            st_reg <= 4'hF;
        end
        else
        begin
            up_reg <= module_reset_n_in ? up_reg + 28'(~&up_reg) : 28'h0;
            lo_reg <= module_reset_n_in ? lo_reg + 4'(~&lo_reg) : 4'h0;
            st_reg <= (scl_in && $rose(sda_in)) ? 4'h0
                                                : st_reg + 4'(~&st_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence desel_s;
        module_select_n_in [*6];
    endsequence

    sequence up_s;
        $rose(ready_out);
    endsequence

    a_sel_release: assert property (desel_s |-> sda_oe_n_out)
        else $error("sda held while deselected");
    a_quiet_unready: assert property (!ready_out |-> sda_oe_n_out)
        else $error("bus answered before ready");
    a_sda_low_phase: assert property ($changed(sda_oe_n_out)
        |-> !scl_in || module_select_n_in)
        else $error("sda changed while scl high");
    a_init_time: assert property (up_s
        |-> up_reg + 28'h2 >= INIT && up_reg <= INIT + 28'h00A)
        else $error("ready at wrong time");
    a_init_irq: assert property (up_s |-> ##[0:2] !interrupt_n_out)
        else $error("no interrupt at ready");
    a_reset_cause: assert property ($fell(ready_out) |-> lo_reg < 4'h8)
        else $error("ready dropped without reset");
    a_rate_after_stop: assert property ($changed(rate_select_out)
        |-> st_reg < 4'hC || lo_reg < 4'h8)
        else $error("rate changed without stop");
    a_lp_pin: assert property ($rose(low_power_pin_in)
        |-> ##[1:5] low_power_out)
        else $error("low power late");
endmodule

bind mts_slave mts_chk #(.INIT(INIT_CYC)) u_chk
(
    .clk_in,
    .rst_in,
    .scl_in,
    .sda_in,
    .module_select_n_in,
    .module_reset_n_in,
    .low_power_pin_in,
    .sda_oe_n_out,
    .interrupt_n_out,
    .low_power_out,
    .rate_select_out,
    .ready_out
);

// ==== verif/mts_host.sv ====
`timescale 1ns/1ps
module mts_host
(
    output logic      scl_out,
    output logic      sda_out,
    input  wire logic sda_in
);
    // Idle released, clock stands still
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic start;
        sda_out = 1'b1;
        #40 scl_out = 1'b1;
        #40 sda_out = 1'b0;
        #40 scl_out = 1'b0;
        #40;
    endtask

    task automatic stop;
        sda_out = 1'b0;
        #40 scl_out = 1'b1;
        #40 sda_out = 1'b1;
        #80;
    endtask

    // Byte MSB first, then acknowledge bit
    task automatic xb(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
        for (int i = 8; i >= 0; i--)
        begin
            sda_out = (i > 0) ? d[i-1] : a;
            #40 scl_out = 1'b1;
            #40;
            if (i > 0)
                q[i-1] = sda_in;
            else
                k = sda_in;
            #40 scl_out = 1'b0;
            #40;
        end
    endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic        clk_in  = 1'b0;
    logic        rst_in  = 1'b1;
    logic        scl;
    logic        sda_h;
    logic        sda_w;
    logic        msel_n  = 1'b0;
    logic        mrst_n  = 1'b1;
    logic        lp_pin  = 1'b0;
    logic [3:0]  los     = 4'h0;
    logic [3:0]  txf     = 4'h0;
    logic        sda_o;
    logic        oe_n;
    logic        int_n;
    logic        lp;
    logic [7:0]  rate;
    logic        rdy;
    logic [31:0] na      = 32'h0;
    logic [31:0] rb;
    int          n_fail  = 0;
    int          checked = 0;
    // Address, data, readback, {pin, low power}
    logic [31:0] rows [10] = '{32'h57A5A500, 32'h640F0F00, 32'h0033C300,
        32'h7F020200, 32'h803C3C00, 32'h7F030311, 32'h814B4B11,
        32'h5D010110, 32'h5D030301, 32'h5D000000};

    always #5 clk_in = ~clk_in;
    assign sda_w = sda_h & (oe_n | sda_o);

    mts_host u_host
    (
        .scl_out (scl),
        .sda_out (sda_h),
        .sda_in  (sda_w)
    );

    mts_slave
    #(
        .INIT_CYC (28'h0000190),
        .WR_CYC   (28'h0000064),
        .ID_BYTE  (8'hC3)
    )
    u_dut
    (
        .clk_in             (clk_in),
        .rst_in             (rst_in),
        .scl_in             (scl),
        .sda_in             (sda_w),
        .module_select_n_in (msel_n),
        .module_reset_n_in  (mrst_n),
        .low_power_pin_in   (lp_pin),
        .rx_los_in          (los),
        .tx_fault_in        (txf),
        .sda_out            (sda_o),
        .sda_oe_n_out       (oe_n),
        .interrupt_n_out    (int_n),
        .low_power_out      (lp),
        .rate_select_out    (rate),
        .ready_out          (rdy)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic x(input logic [7:0] d, input logic a);
        logic [7:0] q;
        logic       k;
        u_host.xb(d, a, q, k);
        na = na + 32'(k);
        rb = {rb[23:0], q};
    endtask

    task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d,
                      input logic sr);
        repeat (120) @(negedge clk_in);
        na = 32'h0;
        u_host.start();
        x(8'hA0, 1'b1);
        x(a, 1'b1);
        for (int i = 0; i < n; i++)
            x(d + 8'(i), 1'b1);
        if (sr)
            u_host.start();
        u_host.stop();
    endtask

    task automatic rd(input logic [7:0] a, input int n);
        repeat (120) @(negedge clk_in);
        na = 32'h0;
        u_host.start();
        x(8'hA0, 1'b1);
        x(a, 1'b1);
        u_host.start();
        x(8'hA1, 1'b1);
        for (int i = 1; i <= n; i++)
            x(8'hFF, i == n);
        u_host.stop();
    endtask

    task automatic wait_ready;
        for (int i = 0; i < 1000 && rdy !== 1'b1; i++)
            @(negedge clk_in);
    endtask

    initial
    begin
        #1000000;
        n_fail++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        chk(32'({rdy, int_n, lp, rate}), 32'h200);
        u_host.start();
        x(8'hA1, 1'b1);
        u_host.stop();
        chk(na, 32'h1);
        wait_ready();
        chk(32'(int_n), 32'h0);
        rd(8'h02, 1);
        chk(32'(rb[7:0]), 32'h04);
        chk(32'(int_n), 32'h1);
        for (int i = 0; i < 10; i++)
        begin
            lp_pin = rows[i][4];
            wr(rows[i][31:24], 1, rows[i][23:16], 1'b0);
            chk(na, 32'h0);
            rd(rows[i][31:24], 1);
            chk(32'(rb[7:0]), 32'(rows[i][15:8]));
            chk(32'(lp), 32'(rows[i][0]));
        end
        chk(32'(rate), 32'hA5);
        @(negedge clk_in) los = 4'h1;
        repeat (10) @(negedge clk_in);
        los = 4'h0;
        chk(32'(int_n), 32'h1);
        wr(8'h64, 1, 8'h00, 1'b0);
        repeat (20) @(negedge clk_in);
        chk(32'(int_n), 32'h0);
        rd(8'h03, 1);
        chk(32'(rb[7:0]), 32'h01);
        chk(32'(int_n), 32'h1);
        txf = 4'h2;
        repeat (5) @(negedge clk_in);
        txf = 4'h0;
        chk(32'(int_n), 32'h0);
        rd(8'h04, 1);
        chk(32'(rb[7:0]), 32'h02);
        wr(8'h58, 4, 8'h10, 1'b0);
        chk(na, 32'h0);
        rd(8'h58, 4);
        chk(rb, 32'h10111213);
        wr(8'h58, 5, 8'h20, 1'b0);
        chk(na, 32'h1);
        wr(8'h58, 1, 8'h30, 1'b1);
        rd(8'h58, 1);
        chk(32'(rb[7:0]), 32'h10);
        wr(8'h59, 1, 8'h44, 1'b0);
        u_host.start();
        na = 32'h0;
        x(8'hA1, 1'b1);
        u_host.stop();
        chk(na, 32'h1);
        @(negedge clk_in) msel_n = 1'b1;
        rd(8'h58, 1);
        chk(na, 32'h4);
        @(negedge clk_in) msel_n = 1'b0;
        mrst_n = 1'b0;
        repeat (50) @(negedge clk_in);
        mrst_n = 1'b1;
        repeat (10) @(negedge clk_in);
        chk(32'(rdy), 32'h1);
        mrst_n = 1'b0;
        repeat (250) @(negedge clk_in);
        mrst_n = 1'b1;
        repeat (10) @(negedge clk_in);
        chk(32'({rdy, rate}), 32'h0);
        wait_ready();
        chk(32'(int_n), 32'h0);
        conclude();
    end
endmodule
